// file: core/cms_pkg.sv
// Purpose: constants, types and register map of the charge mode sequencer
// Assumes: 100 MHz core clock, comparator levels come from the analog side
// Notes: Operation
package cms_pkg;
   localparam longint unsigned CLK_HZ = 100_000_000;
   localparam longint unsigned SEC_PER_MIN = 60;
   localparam longint unsigned TRK_LIMIT_MIN = 60;
   localparam longint unsigned CHG_LIMIT_MIN = 600;
   localparam longint unsigned WD_PERIOD_S = 32;
   localparam longint unsigned SAFE_PERIOD_MIN = 40;
   localparam longint unsigned END_TIME_MS = 31;
   localparam longint unsigned TRK_CYC = TRK_LIMIT_MIN * SEC_PER_MIN * CLK_HZ;
   localparam longint unsigned CHG_CYC = CHG_LIMIT_MIN * SEC_PER_MIN * CLK_HZ;
   localparam longint unsigned WD_CYC = WD_PERIOD_S * CLK_HZ;
   localparam longint unsigned SAFE_CYC = SAFE_PERIOD_MIN * SEC_PER_MIN * CLK_HZ;
   localparam longint unsigned END_CYC = END_TIME_MS * CLK_HZ / 1000;
   // wide enough for the full fast-charge limit at the core clock
   localparam int TMR_W = 42;
   // register map
   localparam logic [7:0] REG_CTRL = 8'h01;
   localparam logic [7:0] REG_STATUS = 8'h0b;
   localparam logic [7:0] REG_FAULT = 8'h0d;
   localparam int CTRL_CHARGING_ENABLE_BIT = 0;
   localparam int CTRL_TRICKLE_ENABLE_BIT = 1;
   localparam int CTRL_KICK = 2;
   localparam int ST_DONE_BIT = 3;
   localparam int ST_THERM_BIT = 4;
   localparam int FLT_TSD = 0;
   localparam int FLT_WARN = 1;
   localparam int FLT_CHG = 2;
   localparam logic [1:0] CTRL_RST = 2'h3;
   // arbitrary bus address
   localparam logic [6:0] DEV_ADDR = 7'h2a;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   // charge state codes
   localparam logic [2:0] CODE_OFF = 3'h0;
   localparam logic [2:0] CODE_TRK = 3'h1;
   localparam logic [2:0] CODE_CC = 3'h2;
   localparam logic [2:0] CODE_CV = 3'h3;
   localparam logic [2:0] CODE_DONE = 3'h4;
   localparam logic [2:0] CODE_WEAK = 3'h5;
   localparam logic [2:0] CODE_FAULT = 3'h6;
   localparam logic [2:0] CODE_SAFE = 3'h7;
   typedef enum logic [2:0] {
      ST_OFF = 3'b000, ST_TRK = 3'b001, ST_WEAK = 3'b011, ST_CC = 3'b010,
      ST_CV = 3'b110, ST_DONE = 3'b111, ST_SAFE = 3'b101, ST_FAULT = 3'b100
   } cms_state_t;
   typedef enum logic [2:0] {
      I_IDLE = 3'b000, I_ADDR = 3'b001, I_REG = 3'b011, I_WR = 3'b010, I_RD = 3'b110
   } cms_i2c_t;
   typedef struct packed {
      logic die_over_warn;
      logic die_over_sd;
      logic die_at_limit;
      logic at_recharge;
      logic below_end;
      logic at_term;
      logic below_weak;
      logic below_dead;
   } cms_cmp_t;
   typedef struct packed {
      logic charger_on;
      logic trickle_current;
      logic sys_trickle_reg;
      logic iso_fet_off;
      logic weak_mode;
      logic input_current_limit_default;
      logic cv_mode;
   } cms_drive_t;
endpackage : cms_pkg

// file: core/cms_timer.sv
// Purpose: run-gated cycle timer with sticky expiry
// Assumes: run low clears the count
// Notes: expired rises after limit cycles of continuous run
`timescale 1ns/1ps
`default_nettype none
module cms_timer #(
   parameter int W = 40
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // control
   input wire logic run_in,
   input wire logic [W-1:0] limit_in,
   // status
   output logic expired_out
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge clk_in) begin
      if (rst_in || !run_in) begin
         cnt_q <= '0;
         expired_out <= 1'b0;
      end else if (cnt_q >= limit_in - W'(1)) begin
         expired_out <= 1'b1;
      end else begin
         cnt_q <= cnt_q + W'(1);
      end
   end
endmodule : cms_timer
`default_nettype wire

// file: core/cms_top.sv
// Purpose: charge mode sequencer with its serial register slave
// Assumes: comparators and pins are asynchronous to mclk_in
// Notes: time limits are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
module cms_top #(
   parameter longint unsigned TRK_CYC = cms_pkg::TRK_CYC,
   parameter longint unsigned CHG_CYC = cms_pkg::CHG_CYC,
   parameter longint unsigned WD_CYC = cms_pkg::WD_CYC,
   parameter longint unsigned SAFE_CYC = cms_pkg::SAFE_CYC,
   parameter longint unsigned END_CYC = cms_pkg::END_CYC
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // analog comparators and trickle pin
   input wire cms_pkg::cms_cmp_t cmp_in,
   input wire logic trickle_disable_pin_in,
   // serial register bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   // charger drive and status
   output cms_pkg::cms_drive_t drive_out,
   output logic [2:0] charge_state_out,
   output logic charge_done_flag_out,
   output logic thermal_limit_flag_out
);
   localparam int TW = cms_pkg::TMR_W;
   localparam int NS = $bits(cms_pkg::cms_cmp_t) + 3;

   logic [NS-1:0] meta_q, sync_q;
   cms_pkg::cms_cmp_t cmp_s;
   logic trk_pin_s, scl_s, sda_s, scl_p_q, sda_p_q;
   cms_pkg::cms_state_t state_q, state_d;
   cms_pkg::cms_i2c_t ph_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q, rd_q, ptr_q;
   logic charging_enable_bit_q, trickle_enable_bit_q, trk_written_q, kick_q;
   logic [2:0] fault_q;
   logic done_q, wd_started_q, safety_q;
   logic trk_exp, chg_exp, wd_exp, safe_exp, end_exp;
   logic charging, chg_ok, trk_ok, rise, fall, start, stop, wr_stb;

   // synchronisers: second stage only is read
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= {cmp_in, trickle_disable_pin_in, scl_in, sda_in};
         sync_q <= meta_q;
      end
   end
   assign {cmp_s, trk_pin_s, scl_s, sda_s} = sync_q;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end
   assign rise = scl_s && !scl_p_q;
   assign fall = !scl_s && scl_p_q;
   assign start = scl_s && scl_p_q && sda_p_q && !sda_s;
   assign stop = scl_s && scl_p_q && !sda_p_q && sda_s;
   assign wr_stb = fall && bit_q == cms_pkg::ACK_SLOT && ph_q == cms_pkg::I_WR;

   function automatic logic [7:0] rd_mux(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == cms_pkg::REG_CTRL) begin
         v[cms_pkg::CTRL_CHARGING_ENABLE_BIT] = charging_enable_bit_q;
         v[cms_pkg::CTRL_TRICKLE_ENABLE_BIT] = trickle_enable_bit_q;
      end else if (a == cms_pkg::REG_STATUS) begin
         v[2:0] = charge_state_out;
         v[cms_pkg::ST_DONE_BIT] = charge_done_flag_out;
         v[cms_pkg::ST_THERM_BIT] = thermal_limit_flag_out;
      end else if (a == cms_pkg::REG_FAULT) begin
         v[2:0] = fault_q;
      end
      return v;
   endfunction : rd_mux

   // serial slave: sample on scl rise, drive on scl fall
   always_ff @(posedge mclk_in) begin
      if (rst_in || stop) begin
         ph_q <= cms_pkg::I_IDLE;
         bit_q <= '0;
         sh_q <= '0;
         rd_q <= '0;
         sda_oe_out <= 1'b0;
         if (rst_in) begin
            ptr_q <= '0;
         end
      end else if (start) begin
         ph_q <= cms_pkg::I_ADDR;
         bit_q <= '0;
         sda_oe_out <= 1'b0;
      end else if (ph_q != cms_pkg::I_IDLE && rise) begin
         if (bit_q != cms_pkg::ACK_SLOT) begin
            sh_q <= {sh_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
         end else begin
            bit_q <= '0;
            // own ack of the read address is not a master ack
            if (ph_q == cms_pkg::I_RD && !sda_oe_out) begin
               if (sda_s) begin
                  ph_q <= cms_pkg::I_IDLE;
               end else begin
                  rd_q <= rd_mux(ptr_q + 8'h01);
                  ptr_q <= ptr_q + 8'h01;
               end
            end
         end
      end else if (ph_q != cms_pkg::I_IDLE && fall) begin
         sda_oe_out <= 1'b0;
         if (ph_q == cms_pkg::I_RD) begin
            if (bit_q != cms_pkg::ACK_SLOT) begin
               sda_oe_out <= !rd_q[7];
               rd_q <= {rd_q[6:0], 1'b0};
            end
         end else if (bit_q == cms_pkg::ACK_SLOT) begin
            sda_oe_out <= 1'b1;
            unique case (ph_q)
               cms_pkg::I_ADDR: begin
                  if (sh_q[7:1] != cms_pkg::DEV_ADDR) begin
                     sda_oe_out <= 1'b0;
                     ph_q <= cms_pkg::I_IDLE;
                  end else if (sh_q[0]) begin
                     ph_q <= cms_pkg::I_RD;
                     rd_q <= rd_mux(ptr_q);
                  end else begin
                     ph_q <= cms_pkg::I_REG;
                  end
               end
               cms_pkg::I_REG: begin
                  ptr_q <= sh_q;
                  ph_q <= cms_pkg::I_WR;
               end
               cms_pkg::I_WR: ptr_q <= ptr_q + 8'h01;
               default: ph_q <= cms_pkg::I_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      sda_out <= 1'b0;
   end

   // control register writes
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         {trickle_enable_bit_q, charging_enable_bit_q} <= cms_pkg::CTRL_RST;
         trk_written_q <= 1'b0;
         kick_q <= 1'b0;
      end else begin
         kick_q <= 1'b0;
         if (wr_stb && ptr_q == cms_pkg::REG_CTRL) begin
            charging_enable_bit_q <= sh_q[cms_pkg::CTRL_CHARGING_ENABLE_BIT];
            trickle_enable_bit_q <= sh_q[cms_pkg::CTRL_TRICKLE_ENABLE_BIT];
            trk_written_q <= 1'b1;
            kick_q <= sh_q[cms_pkg::CTRL_KICK];
         end
      end
   end

   assign trk_ok = trk_written_q ? trickle_enable_bit_q : !trk_pin_s;
   assign chg_ok = charging_enable_bit_q && !fault_q[cms_pkg::FLT_TSD] && !cmp_s.die_over_sd;
   assign charging = state_q inside {cms_pkg::ST_TRK, cms_pkg::ST_WEAK,
                                     cms_pkg::ST_CC, cms_pkg::ST_CV};

   // fault flags: hardware set wins over host clear
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         fault_q <= '0;
      end else begin
         if (wr_stb && ptr_q == cms_pkg::REG_FAULT) begin
            fault_q <= fault_q & ~sh_q[2:0];
         end
         if (cmp_s.die_over_sd) begin
            fault_q[cms_pkg::FLT_TSD] <= 1'b1;
         end
         if (cmp_s.die_over_warn) begin
            fault_q[cms_pkg::FLT_WARN] <= 1'b1;
         end
         if (state_d == cms_pkg::ST_FAULT && state_q != cms_pkg::ST_FAULT) begin
            fault_q[cms_pkg::FLT_CHG] <= 1'b1;
         end
      end
   end

   function automatic cms_pkg::cms_state_t pick(input cms_pkg::cms_cmp_t c, input logic t);
      if (c.below_dead) begin
         return t ? cms_pkg::ST_TRK : cms_pkg::ST_OFF;
      end else if (c.below_weak) begin
         return cms_pkg::ST_WEAK;
      end else if (c.at_term) begin
         return cms_pkg::ST_CV;
      end
      return cms_pkg::ST_CC;
   endfunction : pick

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         cms_pkg::ST_OFF: state_d = pick(cmp_s, trk_ok);
         cms_pkg::ST_TRK: begin
            if (trk_exp) begin
               state_d = cms_pkg::ST_FAULT;
            end else if (!trk_ok || !cmp_s.below_dead) begin
               state_d = pick(cmp_s, trk_ok);
            end
         end
         cms_pkg::ST_WEAK: state_d = pick(cmp_s, trk_ok);
         cms_pkg::ST_CC: begin
            if (chg_exp) begin
               state_d = cms_pkg::ST_FAULT;
            end else if (cmp_s.at_term) begin
               state_d = cms_pkg::ST_CV;
            end else if (cmp_s.below_weak) begin
               state_d = pick(cmp_s, trk_ok);
            end
         end
         cms_pkg::ST_CV: begin
            if (end_exp || chg_exp) begin
               state_d = cms_pkg::ST_DONE;
            end
         end
         cms_pkg::ST_DONE: begin
            if (cmp_s.at_recharge) begin
               state_d = cms_pkg::ST_CV;
            end
         end
         cms_pkg::ST_SAFE: begin
            if (kick_q) begin
               state_d = cms_pkg::ST_OFF;
            end
         end
         cms_pkg::ST_FAULT: begin
            if (!fault_q[cms_pkg::FLT_CHG]) begin
               state_d = cms_pkg::ST_OFF;
            end
         end
      endcase
      if (state_q != cms_pkg::ST_FAULT && state_d != cms_pkg::ST_FAULT) begin
         if (charging && safe_exp) begin
            state_d = cms_pkg::ST_SAFE;
         end
         if (!chg_ok) begin
            state_d = cms_pkg::ST_OFF;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         state_q <= cms_pkg::ST_OFF;
      end else begin
         state_q <= state_d;
      end
   end

   // watchdog and safety; a missed kick sets the default input current limit and ends the charge after the safety period, never at once
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         wd_started_q <= 1'b0;
         safety_q <= 1'b0;
      end else begin
         if (kick_q || !cmp_s.below_weak) begin
            wd_started_q <= 1'b1;
         end
         if (kick_q) begin
            safety_q <= 1'b0;
         end
         if (wd_exp && charging) begin
            safety_q <= 1'b1;
         end
      end
   end

   cms_timer #(.W(TW)) u_trk (.clk_in(mclk_in), .rst_in(rst_in),
      .run_in(state_q == cms_pkg::ST_TRK), .limit_in(TW'(TRK_CYC)), .expired_out(trk_exp));
   cms_timer #(.W(TW)) u_chg (.clk_in(mclk_in), .rst_in(rst_in),
      .run_in(state_q inside {cms_pkg::ST_CC, cms_pkg::ST_CV}),
      .limit_in(TW'(CHG_CYC)), .expired_out(chg_exp));
   cms_timer #(.W(TW)) u_wd (.clk_in(mclk_in), .rst_in(rst_in),
      .run_in(wd_started_q && charging && !kick_q),
      .limit_in(TW'(WD_CYC)), .expired_out(wd_exp));
   cms_timer #(.W(TW)) u_safe (.clk_in(mclk_in), .rst_in(rst_in),
      .run_in(safety_q), .limit_in(TW'(SAFE_CYC)), .expired_out(safe_exp));
   cms_timer #(.W(TW)) u_end (.clk_in(mclk_in), .rst_in(rst_in),
      .run_in(state_q == cms_pkg::ST_CV && cmp_s.below_end),
      .limit_in(TW'(END_CYC)), .expired_out(end_exp));

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         done_q <= 1'b0;
      end else if (state_q == cms_pkg::ST_CV && end_exp) begin
         done_q <= 1'b1;
      end else if (state_q != cms_pkg::ST_DONE) begin
         done_q <= 1'b0;
      end
   end

   // outputs registered from the state, one cycle behind it
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         drive_out <= '0;
         charge_state_out <= cms_pkg::CODE_OFF;
         charge_done_flag_out <= 1'b0;
         thermal_limit_flag_out <= 1'b0;
      end else begin
         drive_out.charger_on <= charging;
         drive_out.trickle_current <= state_q inside {cms_pkg::ST_TRK, cms_pkg::ST_WEAK};
         drive_out.sys_trickle_reg <= state_q == cms_pkg::ST_TRK;
         drive_out.iso_fet_off <= state_q == cms_pkg::ST_TRK;
         drive_out.weak_mode <= state_q == cms_pkg::ST_WEAK;
         drive_out.input_current_limit_default <= state_q == cms_pkg::ST_WEAK || safety_q;
         drive_out.cv_mode <= state_q == cms_pkg::ST_CV;
         charge_done_flag_out <= done_q;
         thermal_limit_flag_out <= cmp_s.die_at_limit && charging;
         unique case (state_q)
            cms_pkg::ST_OFF: charge_state_out <= cms_pkg::CODE_OFF;
            cms_pkg::ST_TRK: charge_state_out <= cms_pkg::CODE_TRK;
            cms_pkg::ST_WEAK: charge_state_out <= cms_pkg::CODE_WEAK;
            cms_pkg::ST_CC: charge_state_out <= cms_pkg::CODE_CC;
            cms_pkg::ST_CV: charge_state_out <= cms_pkg::CODE_CV;
            cms_pkg::ST_DONE: charge_state_out <= cms_pkg::CODE_DONE;
            cms_pkg::ST_SAFE: charge_state_out <= cms_pkg::CODE_SAFE;
            cms_pkg::ST_FAULT: charge_state_out <= cms_pkg::CODE_FAULT;
         endcase
      end
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   AST_TRK_CODE: assert property (state_q == cms_pkg::ST_TRK |=>
      charge_state_out == cms_pkg::CODE_TRK && drive_out.trickle_current)
      else $error("trickle not reported");
   AST_TRK_RAIL: assert property (state_q == cms_pkg::ST_TRK |=>
      drive_out.iso_fet_off && drive_out.sys_trickle_reg)
      else $error("trickle rail or isolation wrong");
   AST_PIN_GATE: assert property (state_q != cms_pkg::ST_TRK
      && state_d == cms_pkg::ST_TRK && !trk_written_q |-> !trk_pin_s)
      else $error("trickle entered with pin high");
   AST_REG_PRIO: assert property (trk_written_q && !trickle_enable_bit_q
      |-> state_d != cms_pkg::ST_TRK)
      else $error("trickle entered with bit clear");
   AST_TRK_TMO: assert property (state_q == cms_pkg::ST_TRK && trk_exp
      |=> state_q == cms_pkg::ST_FAULT ##1 charge_state_out == cms_pkg::CODE_FAULT)
      else $error("trickle timeout missed");
   AST_WEAK_INPUT_CURRENT_LIMIT: assert property (state_q == cms_pkg::ST_WEAK |=>
      drive_out.input_current_limit_default && drive_out.weak_mode)
      else $error("weak mode limit wrong");
   AST_CC_TMO: assert property (state_q == cms_pkg::ST_CC && chg_exp
      |=> state_q == cms_pkg::ST_FAULT && fault_q[cms_pkg::FLT_CHG])
      else $error("fast timeout missed");
   AST_CV_TMO: assert property (state_q == cms_pkg::ST_CV && chg_exp && !end_exp
      && chg_ok |=> state_q == cms_pkg::ST_DONE && !done_q)
      else $error("cv timeout wrong");
   AST_DONE: assert property (state_q == cms_pkg::ST_CV && end_exp |=>
      done_q ##1 charge_done_flag_out)
      else $error("charge done missed");
   AST_RCH: assert property (state_q == cms_pkg::ST_DONE && cmp_s.at_recharge
      && chg_ok |=> state_q == cms_pkg::ST_CV)
      else $error("recharge missed");
   AST_TSD: assert property (cmp_s.die_over_sd |=>
      fault_q[cms_pkg::FLT_TSD] ##1 !drive_out.charger_on)
      else $error("shutdown missed");
   COV_FULL: cover property (state_q == cms_pkg::ST_CC ##1 state_q == cms_pkg::ST_CV);
   COV_DONE: cover property (state_q == cms_pkg::ST_DONE ##1 state_q == cms_pkg::ST_CV);
   COV_FAULT: cover property (state_q == cms_pkg::ST_FAULT ##1 state_q == cms_pkg::ST_OFF);
endmodule : cms_top
`default_nettype wire

// file: dv/cms_host_model.sv
// Purpose: processor model on the serial register port
// Assumes: wired data line with pull-up
// Notes: clock high phase of a data bit held 8 core cycles, low phase 10
`timescale 1ns/1ps
`default_nettype none
module cms_host_model (
   // clock
   input wire logic mclk_in,
   // bus lines
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_low_out
);
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
   endtask : cyc
   // data moves only while the bus clock is low
   task automatic bit_io(input logic b, output logic s);
      cyc(2);
      sda_low_out <= ~b;
      cyc(8);
      scl_out <= 1'b1;
      cyc(8);
      s = sda_in;
      scl_out <= 1'b0;
   endtask : bit_io
   // data falls while the bus clock is high
   task automatic start;
      cyc(2);
      sda_low_out <= 1'b0;
      cyc(8);
      scl_out <= 1'b1;
      cyc(8);
      sda_low_out <= 1'b1;
      cyc(8);
      scl_out <= 1'b0;
   endtask : start
   // data rises while the bus clock is high
   task automatic stop;
      cyc(2);
      sda_low_out <= 1'b1;
      cyc(8);
      scl_out <= 1'b1;
      cyc(8);
      sda_low_out <= 1'b0;
      cyc(8);
   endtask : stop
   task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
         q[i] = s;
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask : xfer
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic k0, k1, k2;
      start();
      xfer({cms_pkg::DEV_ADDR, 1'b0}, q, k0);
      xfer(a, q, k1);
      xfer(d, q, k2);
      stop();
      ok = k0 & k1 & k2;
   endtask : write_reg
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
      logic [7:0] q;
      logic k0, k1, k2, k3;
      start();
      xfer({cms_pkg::DEV_ADDR, 1'b0}, q, k0);
      xfer(a, q, k1);
      start();
      xfer({cms_pkg::DEV_ADDR, 1'b1}, q, k2);
      xfer(8'hff, d, k3);
      stop();
      ok = k0 & k1 & k2;
   endtask : read_reg
endmodule : cms_host_model
`default_nettype wire

// file: dv/cms_top_tb.sv
// Purpose: self-checking bench of the charge mode sequencer
// Assumes: timers shortened through parameters
// Notes: host model stands in for the processor
`timescale 1ns/1ps
`default_nettype none
module cms_top_tb;
   localparam longint unsigned TRK = 600;
   localparam longint unsigned CHG = 1000;
   localparam longint unsigned WD = 3000;
   localparam longint unsigned SAFE = 400;
   localparam longint unsigned ENDC = 50;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic pin = 1'b1;
   cms_pkg::cms_cmp_t cmp = 8'h03;
   logic scl, sda_low, sda_out, sda_oe, done_flag, therm_flag;
   wire logic sda = ~(sda_low | (sda_oe & ~sda_out));
   cms_pkg::cms_drive_t drv;
   logic [2:0] code;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   always #5 mclk_in = ~mclk_in;
   cms_top #(.TRK_CYC(TRK), .CHG_CYC(CHG), .WD_CYC(WD), .SAFE_CYC(SAFE), .END_CYC(ENDC)) uut (
      .mclk_in(mclk_in), .rst_in(rst_in), .cmp_in(cmp), .trickle_disable_pin_in(pin),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe),
      .drive_out(drv), .charge_state_out(code), .charge_done_flag_out(done_flag),
      .thermal_limit_flag_out(therm_flag));
   cms_host_model host (.mclk_in(mclk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
   task automatic finish_test;
      if (num_errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic cyc(input longint unsigned n);
      repeat (n) @(posedge mclk_in);
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      host.write_reg(a, d, ok);
      chk("write ack", 8'h01, 8'(ok));
      cyc(8);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      host.read_reg(a, d, ok);
      chk("read ack", 8'h01, 8'(ok));
      chk("read data", exp, d);
   endtask : rd
   task automatic cm(input logic [7:0] v, input longint unsigned n);
      cmp <= cms_pkg::cms_cmp_t'(v);
      cyc(n);
   endtask : cm
   task automatic st(input logic [2:0] exp);
      chk("charge state", 8'(exp), 8'(code));
   endtask : st
   task automatic on(input logic exp);
      chk("charger on", 8'(exp), 8'(drv.charger_on));
   endtask : on
   // hang guard, runs far longer than the whole sequence
   always @(posedge mclk_in) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         num_errors++;
         finish_test();
      end
   end
   initial begin
      cyc(5);
      chk("drive in reset", 8'h00, 8'(drv));
      rst_in <= 1'b0;
      cyc(8);
      st(cms_pkg::CODE_OFF);
      rd(cms_pkg::REG_CTRL, 8'h03);
      rd(cms_pkg::REG_FAULT, 8'h00);
      rd(8'h05, 8'h00);
      pin <= 1'b0;
      cyc(8);
      st(cms_pkg::CODE_TRK);
      chk("trickle drive", 8'h78, 8'(drv));
      pin <= 1'b1;
      cyc(8);
      st(cms_pkg::CODE_OFF);
      wr(cms_pkg::REG_CTRL, 8'h01);
      pin <= 1'b0;
      cyc(8);
      st(cms_pkg::CODE_OFF);
      pin <= 1'b1;
      wr(cms_pkg::REG_CTRL, 8'h03);
      st(cms_pkg::CODE_TRK);
      cyc(TRK - 100);
      st(cms_pkg::CODE_TRK);
      cyc(100);
      st(cms_pkg::CODE_FAULT);
      on(1'b0);
      cm(8'h02, 8);
      rd(cms_pkg::REG_FAULT, 8'h04);
      wr(cms_pkg::REG_FAULT, 8'h04);
      st(cms_pkg::CODE_WEAK);
      chk("weak drive", 8'h66, 8'(drv));
      wr(cms_pkg::REG_CTRL, 8'h07);
      cyc(WD + SAFE - 60);
      st(cms_pkg::CODE_WEAK);
      cyc(120);
      st(cms_pkg::CODE_SAFE);
      cm(8'h00, 4);
      wr(cms_pkg::REG_CTRL, 8'h07);
      st(cms_pkg::CODE_CC);
      cm(8'h04, 8);
      st(cms_pkg::CODE_CV);
      chk("cv drive", 8'h01, 8'(drv.cv_mode));
      cm(8'h0c, 30);
      cm(8'h04, 8);
      cm(8'h0c, ENDC - 15);
      st(cms_pkg::CODE_CV);
      cyc(25);
      st(cms_pkg::CODE_DONE);
      chk("done flag", 8'h01, 8'(done_flag));
      cm(8'h10, 8);
      st(cms_pkg::CODE_CV);
      cm(8'h04, CHG + 20);
      st(cms_pkg::CODE_DONE);
      chk("done flag", 8'h00, 8'(done_flag));
      cm(8'h10, 8);
      st(cms_pkg::CODE_CV);
      wr(cms_pkg::REG_CTRL, 8'h06);
      st(cms_pkg::CODE_OFF);
      cm(8'h00, 4);
      wr(cms_pkg::REG_CTRL, 8'h07);
      on(1'b1);
      cm(8'h20, 8);
      chk("thermal flag", 8'h01, 8'(therm_flag));
      cm(8'h80, 8);
      on(1'b1);
      cm(8'hc0, 8);
      on(1'b0);
      cm(8'h00, 8);
      on(1'b0);
      rd(cms_pkg::REG_FAULT, 8'h03);
      wr(cms_pkg::REG_FAULT, 8'h03);
      st(cms_pkg::CODE_CC);
      cyc(CHG - 100);
      st(cms_pkg::CODE_CC);
      cyc(100);
      st(cms_pkg::CODE_FAULT);
      wr(cms_pkg::REG_FAULT, 8'h04);
      st(cms_pkg::CODE_CC);
      finish_test();
   end
endmodule : cms_top_tb
`default_nettype wire
